//--- src/bus_flags_pkg.sv
// constants for the two-wire bus status flag block
// Notes on behaviour
// - status register is read-only; a write only clears the lost flag
// - reset clears every status bit to zero
// - flag order bit7 down: master..stop detected
// - generated start sets master active flag
// - master flag clears on stop, loss, exit, disable
// - arbitration loss sets lost, clears master together
// - lost flag zero means none or won
// - lost flag clears on read, bit access, disable
// - upper address nibble 0000/1111 sets extension flag
// - address equal local address sets match flag
// - extension/match clear on start, stop, exit, disable
// - receive state keeps data driver high impedance
package bus_flags_pkg;

    // status register index as printed; byte address is four times it
    localparam logic [31:0] STATUS_IDX = 32'hFFFFFD86;
    localparam logic [31:0] STATUS_ADDR = {STATUS_IDX[29:0], 2'b00};
    localparam logic [31:0] CONTROL_ADDR = 32'hFFFFF600;
    localparam logic [31:0] SLAVE_ADDR_ADDR = 32'hFFFFF604;
    localparam logic [31:0] IRQ_STATUS_ADDR = 32'hFFFFF608;
    localparam logic [31:0] IRQ_MASK_ADDR = 32'hFFFFF60C;

    // bus_status field positions
    localparam int MASTER_BIT = 7;
    localparam int ARB_LOST_BIT = 6;
    localparam int EXT_CODE_BIT = 5;
    localparam int ADDR_MATCH_BIT = 4;
    localparam int TX_STATE_BIT = 3;
    localparam int ACK_BIT = 2;
    localparam int START_BIT = 1;
    localparam int STOP_BIT = 0;

    // bus_control field positions
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_START_TRIG_BIT = 1;
    localparam int CTRL_EXIT_BIT = 2;

    // interrupt event positions
    localparam int IRQ_ARB_BIT = 0;
    localparam int IRQ_EXT_BIT = 1;
    localparam int IRQ_MATCH_BIT = 2;
    localparam int IRQ_START_BIT = 3;
    localparam int IRQ_STOP_BIT = 4;
    localparam int IRQ_WIDTH = 5;

    // reset values and counts
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [4:0] IRQ_RESET = 5'h00;
    localparam logic [3:0] ADDR_LAST_BIT = 4'h7;
    localparam logic [3:0] EXT_LOW = 4'h0;
    localparam logic [3:0] EXT_HIGH = 4'hF;

    typedef enum logic [1:0] {MON_IDLE, MON_ADDR, MON_DATA} mon_state_t;

endpackage

//--- src/bus_line_monitor.sv
// watches the scl/sda pins for start, stop and the address byte
`timescale 1ns/1ps
module bus_line_monitor (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // bus pins
    input wire logic sclIn,
    input wire logic sdaIn,
    // observed events
    output logic startSeen,
    output logic stopSeen,
    output logic eighthEdge,
    output logic [7:0] rxAddr
);
    logic [1:0] sclSync_reg;
    logic [1:0] sdaSync_reg;
    logic sclPrev_reg;
    logic sdaPrev_reg;
    logic [3:0] bitCnt_reg;
    logic [6:0] shift_reg;
    bus_flags_pkg::mon_state_t state_reg;
    logic sclRise;
    logic startNow;
    logic stopNow;

    // two flops on each pin; only stage one reads stage zero
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            sclSync_reg <= 2'h3;
            sdaSync_reg <= 2'h3;
            sclPrev_reg <= 1'b1;
            sdaPrev_reg <= 1'b1;
        end
        else
        begin
            sclSync_reg <= {sclSync_reg[0], sclIn};
            sdaSync_reg <= {sdaSync_reg[0], sdaIn};
            sclPrev_reg <= sclSync_reg[1];
            sdaPrev_reg <= sdaSync_reg[1];
        end
    end

    // sda moving while scl high marks start or stop
    assign sclRise = sclSync_reg[1] & ~sclPrev_reg;
    assign startNow = sclSync_reg[1] & sclPrev_reg & sdaPrev_reg & ~sdaSync_reg[1];
    assign stopNow = sclSync_reg[1] & sclPrev_reg & ~sdaPrev_reg & sdaSync_reg[1];

    // first byte after a start is the address
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            state_reg <= bus_flags_pkg::MON_IDLE;
            bitCnt_reg <= 4'h0;
            shift_reg <= 7'h00;
            eighthEdge <= 1'b0;
            rxAddr <= bus_flags_pkg::BYTE_RESET;
        end
        else
        begin
            eighthEdge <= 1'b0;
            if (startNow)
            begin
                state_reg <= bus_flags_pkg::MON_ADDR;
                bitCnt_reg <= 4'h0;
            end
            else if (stopNow)
                state_reg <= bus_flags_pkg::MON_IDLE;
            else if (sclRise && state_reg == bus_flags_pkg::MON_ADDR)
            begin
                shift_reg <= {shift_reg[5:0], sdaSync_reg[1]};
                bitCnt_reg <= bitCnt_reg + 4'h1;
                if (bitCnt_reg == bus_flags_pkg::ADDR_LAST_BIT)
                begin
                    eighthEdge <= 1'b1;
                    rxAddr <= {shift_reg, sdaSync_reg[1]};
                    state_reg <= bus_flags_pkg::MON_DATA;
                end
            end
        end
    end

    // start and stop pulses registered for timing
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            startSeen <= 1'b0;
            stopSeen <= 1'b0;
        end
        else
        begin
            startSeen <= startNow;
            stopSeen <= stopNow;
        end
    end

endmodule

//--- src/bus_status_flags.sv
// status flag logic of the two-wire bus controller with its AHB-Lite slave
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
module bus_status_flags (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // events from the shift engine, same clock
    input wire logic startGenerated,
    input wire logic arbLost,
    input wire logic transmitState,
    input wire logic ackDetected,
    input wire logic startDetected,
    input wire logic stopDetected,
    input wire logic sdaDrive,
    // bus pins
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOeN,
    // interrupt
    output logic irq
);
    // flag state
    logic masterActive_reg;
    logic arbLostFlag_reg;
    logic extCode_reg;
    logic addrMatch_reg;
    // control and software registers
    logic enable_reg;
    logic enablePrev_reg;
    logic startTrigger_reg;
    logic [7:0] localSlaveAddr_reg;
    logic [4:0] irqStatus_reg;
    logic [4:0] irqMask_reg;
    // data phase bookkeeping
    logic dataWrite_reg;
    logic dataRead_reg;
    logic [31:0] dataAddr_reg;
    // decoded strobes and monitor outputs
    logic addrPhase;
    logic exitWrite;
    logic enableFall;
    logic statusRead;
    logic statusWrite;
    logic startSeen;
    logic stopSeen;
    logic eighthEdge;
    logic [7:0] rxAddr;
    logic extHit;
    logic matchHit;
    logic [7:0] statusByte;
    logic [4:0] irqEvents;

    ////////////////////////////////////////////////////////////////////////////
    // pin monitor

    bus_line_monitor monitor (
        .mclk(mclk),
        .resetn(resetn),
        .sclIn(sclIn),
        .sdaIn(sdaIn),
        .startSeen(startSeen),
        .stopSeen(stopSeen),
        .eighthEdge(eighthEdge),
        .rxAddr(rxAddr)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus slave

    // the full word is compared, so an alias in the upper bits never hits
    // tests one decoded address
    function automatic logic hitAt(input logic [31:0] addr, input logic [31:0] target);
        hitAt = (addr == target);
    endfunction

    // hsize is not decoded: every register sits in the low byte lanes
    // zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addrPhase = hsel & htrans[1] & hready;

    // address phase captured for the data phase
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            dataWrite_reg <= 1'b0;
            dataRead_reg <= 1'b0;
            dataAddr_reg <= 32'h00000000;
        end
        else if (hready)
        begin
            dataWrite_reg <= addrPhase & hwrite;
            dataRead_reg <= addrPhase & ~hwrite;
            dataAddr_reg <= haddr;
        end
    end

    // decoded write and read side effects
    assign exitWrite = dataWrite_reg & hitAt(dataAddr_reg, bus_flags_pkg::CONTROL_ADDR)
        & hwdata[bus_flags_pkg::CTRL_EXIT_BIT];
    assign statusRead = dataRead_reg & hitAt(dataAddr_reg, bus_flags_pkg::STATUS_ADDR);
    assign statusWrite = dataWrite_reg & hitAt(dataAddr_reg, bus_flags_pkg::STATUS_ADDR);
    assign enableFall = enablePrev_reg & ~enable_reg;

    // a status read clears lost arbitration only after its data phase
    // read data staged at the address phase so it stands from a flop
    always_ff @(posedge mclk)
    begin
        if (!resetn)
            hrdata <= 32'h00000000;
        else if (addrPhase && !hwrite)
        begin
            if (hitAt(haddr, bus_flags_pkg::STATUS_ADDR))
                hrdata <= {24'h000000, statusByte};
            else if (hitAt(haddr, bus_flags_pkg::CONTROL_ADDR))
                hrdata <= {29'h00000000, 1'b0, startTrigger_reg, enable_reg};
            else if (hitAt(haddr, bus_flags_pkg::SLAVE_ADDR_ADDR))
                hrdata <= {24'h000000, localSlaveAddr_reg};
            else if (hitAt(haddr, bus_flags_pkg::IRQ_STATUS_ADDR))
                hrdata <= {27'h0000000, irqStatus_reg};
            else if (hitAt(haddr, bus_flags_pkg::IRQ_MASK_ADDR))
                hrdata <= {27'h0000000, irqMask_reg};
            else
                hrdata <= 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control register

    // a fall of enable shows one cycle late, through enablePrev_reg
    // enable and local address are plain software state
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            enable_reg <= 1'b0;
            enablePrev_reg <= 1'b0;
            localSlaveAddr_reg <= bus_flags_pkg::BYTE_RESET;
        end
        else
        begin
            enablePrev_reg <= enable_reg;
            if (dataWrite_reg && hitAt(dataAddr_reg, bus_flags_pkg::CONTROL_ADDR))
                enable_reg <= hwdata[bus_flags_pkg::CTRL_ENABLE_BIT];
            if (dataWrite_reg && hitAt(dataAddr_reg, bus_flags_pkg::SLAVE_ADDR_ADDR))
                localSlaveAddr_reg <= hwdata[7:0];
        end
    end

    // start trigger stays set until the start goes out or is abandoned
    always_ff @(posedge mclk)
    begin
        if (!resetn)
            startTrigger_reg <= 1'b0;
        else if (dataWrite_reg && hitAt(dataAddr_reg, bus_flags_pkg::CONTROL_ADDR)
            && hwdata[bus_flags_pkg::CTRL_START_TRIG_BIT])
            startTrigger_reg <= 1'b1;
        else if (startGenerated || arbLost || exitWrite || enableFall)
            startTrigger_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // status flags, all on mclk

    // engine pulses share mclk, so they need no synchroniser here
    // master active: generated start sets it; loss wins over a same-cycle start
    always_ff @(posedge mclk)
    begin
        if (!resetn)
            masterActive_reg <= 1'b0;
        else if (stopSeen || arbLost || exitWrite || enableFall)
            masterActive_reg <= 1'b0;
        else if (startGenerated)
            masterActive_reg <= 1'b1;
    end

    // arbitration lost: a loss beside a clearing read is kept, not dropped
    always_ff @(posedge mclk)
    begin
        if (!resetn)
            arbLostFlag_reg <= 1'b0;
        else if (arbLost)
            arbLostFlag_reg <= 1'b1;
        else if (statusRead || statusWrite || enableFall)
            arbLostFlag_reg <= 1'b0;
    end

    // bit zero of the local address is the direction bit and is ignored
    // address checks only count while the controller is enabled
    assign extHit = enable_reg & eighthEdge
        & (rxAddr[7:4] == bus_flags_pkg::EXT_LOW || rxAddr[7:4] == bus_flags_pkg::EXT_HIGH);
    assign matchHit = enable_reg & eighthEdge & (rxAddr[7:1] == localSlaveAddr_reg[7:1]);

    // extension code flag
    always_ff @(posedge mclk)
    begin
        if (!resetn)
            extCode_reg <= 1'b0;
        else if (extHit)
            extCode_reg <= 1'b1;
        else if (startSeen || stopSeen || exitWrite || enableFall)
            extCode_reg <= 1'b0;
    end

    // address match flag
    always_ff @(posedge mclk)
    begin
        if (!resetn)
            addrMatch_reg <= 1'b0;
        else if (matchHit)
            addrMatch_reg <= 1'b1;
        else if (startSeen || stopSeen || exitWrite || enableFall)
            addrMatch_reg <= 1'b0;
    end

    // status byte in documented bit order; engine bits pass only while enabled
    always_comb
    begin
        statusByte = bus_flags_pkg::STATUS_RESET;
        statusByte[bus_flags_pkg::MASTER_BIT] = masterActive_reg;
        statusByte[bus_flags_pkg::ARB_LOST_BIT] = arbLostFlag_reg;
        statusByte[bus_flags_pkg::EXT_CODE_BIT] = extCode_reg;
        statusByte[bus_flags_pkg::ADDR_MATCH_BIT] = addrMatch_reg;
        statusByte[bus_flags_pkg::TX_STATE_BIT] = transmitState & enable_reg;
        statusByte[bus_flags_pkg::ACK_BIT] = ackDetected & enable_reg;
        statusByte[bus_flags_pkg::START_BIT] = startDetected & enable_reg;
        statusByte[bus_flags_pkg::STOP_BIT] = stopDetected & enable_reg;
    end

    ////////////////////////////////////////////////////////////////////////////
    // data line driver

    // registered so the pin cannot glitch while transmitState settles
    // receive state or disabled leaves the line released
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            sdaOut <= 1'b1;
            sdaOeN <= 1'b1;
        end
        else
        begin
            sdaOut <= sdaDrive;
            sdaOeN <= ~(transmitState & enable_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupts

    // causes of the sticky interrupt bits, one per event
    assign irqEvents[bus_flags_pkg::IRQ_ARB_BIT] = arbLost;
    assign irqEvents[bus_flags_pkg::IRQ_EXT_BIT] = extHit;
    assign irqEvents[bus_flags_pkg::IRQ_MATCH_BIT] = matchHit;
    assign irqEvents[bus_flags_pkg::IRQ_START_BIT] = startSeen;
    assign irqEvents[bus_flags_pkg::IRQ_STOP_BIT] = stopSeen;

    // sticky bits, write one to clear; a new event wins over the clear
    genvar i;
    generate
        for (i = 0; i < bus_flags_pkg::IRQ_WIDTH; i++)
        begin : gen_irq
            always_ff @(posedge mclk)
            begin
                if (!resetn)
                    irqStatus_reg[i] <= 1'b0;
                else if (irqEvents[i])
                    irqStatus_reg[i] <= 1'b1;
                else if (dataWrite_reg
                    && hitAt(dataAddr_reg, bus_flags_pkg::IRQ_STATUS_ADDR) && hwdata[i])
                    irqStatus_reg[i] <= 1'b0;
            end
        end
    endgenerate

    // mask register, one enables
    always_ff @(posedge mclk)
    begin
        if (!resetn)
            irqMask_reg <= bus_flags_pkg::IRQ_RESET;
        else if (dataWrite_reg && hitAt(dataAddr_reg, bus_flags_pkg::IRQ_MASK_ADDR))
            irqMask_reg <= hwdata[4:0];
    end

    // a level lets several causes share one line; software masks the rest
    // level output straight from the flops
    assign irq = |(irqStatus_reg & irqMask_reg);

endmodule

//--- verif/bus_flags_chk.sv
// assertion checker for the bus status flag block
`timescale 1ns/1ps
module bus_flags_chk (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // AHB-Lite side
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // engine, pins and interrupt
    input wire logic arbLost,
    input wire logic transmitState,
    input wire logic sdaDrive,
    input wire logic sdaOut,
    input wire logic sdaOeN,
    input wire logic irq
);
////////////////////////////////////////////////////////////////////////////////
logic wrPend_reg;
logic [31:0] wrAddr_reg;
logic [4:0] mask_reg;
logic take;
assign take = hsel && htrans[1] && hready;
// shadow of the interrupt mask, so irq can be tied to its cause
always_ff @(posedge mclk)
begin
    if (!resetn)
    begin
        wrPend_reg <= 1'b0;
        wrAddr_reg <= 32'h00000000;
        mask_reg <= 5'h00;
    end
    else
    begin
        wrPend_reg <= take && hwrite;
        wrAddr_reg <= haddr;
        if (wrPend_reg && wrAddr_reg == bus_flags_pkg::IRQ_MASK_ADDR)
            mask_reg <= hwdata[4:0];
    end
end
////////////////////////////////////////////////////////////////////////////////
default clocking @(posedge mclk); endclocking
default disable iff (!resetn);
a_resp_okay:
    assert property (hresp == 1'b0) else $error("response not OKAY");
a_zero_wait:
    assert property (hreadyout == 1'b1) else $error("wait state inserted");
a_reset_quiet:
    assert property (disable iff (1'b0) !resetn |=> hrdata == 32'h00000000 && !irq
        && sdaOeN && sdaOut) else $error("outputs not quiet after reset");
a_upper_zero:
    assert property (hrdata[31:8] == 24'h000000) else $error("read data above byte");
a_rdata_hold:
    assert property (!take |=> $stable(hrdata)) else $error("read data moved unasked");
a_rx_released:
    assert property (!transmitState |=> sdaOeN) else $error("data line driven in receive");
a_drive_copy:
    assert property (!sdaOeN |-> sdaOut == $past(sdaDrive)) else $error("wrong level driven");
a_irq_on_lost:
    assert property (arbLost && mask_reg[bus_flags_pkg::IRQ_ARB_BIT] |=> irq)
        else $error("no interrupt after lost arbitration");
a_irq_masked:
    assert property (mask_reg == 5'h00 |-> !irq) else $error("interrupt while masked");
endmodule

//--- verif/bus_peer_model.sv
// model of another party on the shared two-wire bus
`timescale 1ns/1ps
module bus_peer_model (
    // clock
    input wire logic mclk,
    // open-drain drives, 1 = released
    output logic sclDrv,
    output logic sdaDrv
);
////////////////////////////////////////////////////////////////////////////////
// idle bus: both lines released to the pull-up
initial
begin
    sclDrv = 1'b1;
    sdaDrv = 1'b1;
end
// a leading gap keeps sda from moving in the same step as scl
task automatic half();
    repeat (8) @(posedge mclk);
endtask
// start or repeated start: sda falls while scl is high
task automatic start_cond();
    half();
    sdaDrv <= 1'b1;
    half();
    sclDrv <= 1'b1;
    half();
    sdaDrv <= 1'b0;
    half();
    sclDrv <= 1'b0;
endtask
// eight address bits msb first, then a released ack slot
task automatic send_byte(input logic [7:0] b);
    for (int i = 8; i >= 0; i--)
    begin
        half();
        sdaDrv <= (i == 0) ? 1'b1 : b[i - 1];
        half();
        sclDrv <= 1'b1;
        half();
        sclDrv <= 1'b0;
    end
endtask
// stop: sda rises while scl is high
task automatic stop_cond();
    half();
    sdaDrv <= 1'b0;
    half();
    sclDrv <= 1'b1;
    half();
    sdaDrv <= 1'b1;
    half();
endtask
endmodule

//--- verif/tb.sv
// self-checking bench for the bus status flag block
`timescale 1ns/1ps
module tb;
logic mclk = 1'b0;
logic resetn = 1'b0;
logic hsel = 1'b0;
logic [31:0] haddr = 32'h00000000;
logic [1:0] htrans = 2'h0;
logic hwrite = 1'b0;
logic [31:0] hwdata = 32'h00000000;
logic startGenerated = 1'b0;
logic arbLost = 1'b0;
logic transmitState = 1'b0;
logic ackDetected = 1'b0;
logic startDetected = 1'b0;
logic stopDetected = 1'b0;
logic sdaDrive = 1'b1;
wire logic hready;
logic [31:0] hrdata;
logic hresp, sdaOut, sdaOeN, irq, sclDrv, sdaDrv, sdaLine, rdyHold;
logic [31:0] rd, rdHold;
logic [7:0] frameAddr [3] = '{8'hA5, 8'h0A, 8'hF3};
logic [7:0] frameExp [3] = '{8'h10, 8'h20, 8'h20};
int miscompares = 0;
int cmpCount = 0;
// open-drain sda: anyone pulling low wins over the pull-up
assign sdaLine = sdaDrv & (sdaOeN | sdaOut);
always #10 mclk = ~mclk;
// sample mid-cycle so a read never races the edge that ends it
always @(negedge mclk)
begin
    rdyHold = hready;
    rdHold = hrdata;
end
bus_status_flags i_dut (.mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .startGenerated(startGenerated),
    .arbLost(arbLost), .transmitState(transmitState), .ackDetected(ackDetected),
    .startDetected(startDetected), .stopDetected(stopDetected), .sdaDrive(sdaDrive),
    .sclIn(sclDrv), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .irq(irq));
bus_peer_model i_peer (.mclk(mclk), .sclDrv(sclDrv), .sdaDrv(sdaDrv));
////////////////////////////////////////////////////////////////////////////////
task automatic testDone();
    $display("comparisons %0d mismatches %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask
task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
        miscompares++;
        $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
endtask
// bounded wait for hready; a stuck bus ends the run
task automatic waitRdy();
    int n;
    n = 0;
    do
    begin
        @(posedge mclk);
        n++;
    end
    while (rdyHold !== 1'b1 && n < 100);
    if (rdyHold !== 1'b1)
    begin
        miscompares++;
        testDone();
    end
endtask
task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    waitRdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    waitRdy();
    rd = rdHold;
endtask
task automatic rdChk(input string name, input logic [31:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h00000000);
    check(name, rd, exp);
endtask
// status is read on the main clock only, with the start trigger set
task automatic rdStatus(input logic [7:0] exp);
    xfer(bus_flags_pkg::CONTROL_ADDR, 1'b1, 32'h00000003);
    rdChk("bus_status", bus_flags_pkg::STATUS_ADDR, {24'h000000, exp});
endtask
task automatic evt(input logic s, input logic a);
    startGenerated <= s;
    arbLost <= a;
    @(posedge mclk);
    startGenerated <= 1'b0;
    arbLost <= 1'b0;
    @(posedge mclk);
endtask
////////////////////////////////////////////////////////////////////////////////
initial
begin
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    rdChk("control", bus_flags_pkg::CONTROL_ADDR, 32'h00000000);
    rdChk("irq mask", bus_flags_pkg::IRQ_MASK_ADDR, 32'h00000000);
    rdChk("irq status", bus_flags_pkg::IRQ_STATUS_ADDR, 32'h00000000);
    rdChk("unmapped", 32'hFFFFF6F0, 32'h00000000);
    rdStatus(8'h00);
    xfer(bus_flags_pkg::IRQ_MASK_ADDR, 1'b1, 32'h00000001);
    evt(1'b1, 1'b0);
    rdStatus(8'h80);
    xfer(bus_flags_pkg::STATUS_ADDR, 1'b1, 32'h000000FF);
    rdStatus(8'h80);
    evt(1'b0, 1'b1);
    check("irq", {31'h0, irq}, 32'h00000001);
    rdStatus(8'h40);
    rdStatus(8'h00);
    xfer(bus_flags_pkg::IRQ_STATUS_ADDR, 1'b1, 32'h0000001F);
    // the clear lands at the edge that ends the write; look one edge on
    @(posedge mclk);
    check("irq", {31'h0, irq}, 32'h00000000);
    evt(1'b1, 1'b0);
    xfer(bus_flags_pkg::CONTROL_ADDR, 1'b1, 32'h00000007);
    rdStatus(8'h00);
    // stop on the pins, with the engine's stop level up meanwhile
    evt(1'b1, 1'b0);
    stopDetected <= 1'b1;
    i_peer.start_cond();
    i_peer.stop_cond();
    rdStatus(8'h01);
    stopDetected <= 1'b0;
    evt(1'b0, 1'b1);
    xfer(bus_flags_pkg::CONTROL_ADDR, 1'b1, 32'h00000000);
    rdStatus(8'h00);
    evt(1'b0, 1'b1);
    xfer(bus_flags_pkg::STATUS_ADDR, 1'b1, 32'h00000001);
    rdStatus(8'h00);
    transmitState <= 1'b1;
    ackDetected <= 1'b1;
    startDetected <= 1'b1;
    sdaDrive <= 1'b0;
    rdStatus(8'h0E);
    transmitState <= 1'b0;
    ackDetected <= 1'b0;
    startDetected <= 1'b0;
    sdaDrive <= 1'b1;
    // local address A4 matches A5 too: the direction bit is ignored
    xfer(bus_flags_pkg::SLAVE_ADDR_ADDR, 1'b1, 32'h000000A4);
    for (int i = 0; i < 3; i++)
    begin
        i_peer.start_cond();
        i_peer.send_byte(frameAddr[i]);
        rdStatus(frameExp[i]);
        i_peer.stop_cond();
        rdStatus(8'h00);
    end
    i_peer.start_cond();
    i_peer.send_byte(8'hA5);
    i_peer.start_cond();
    rdStatus(8'h00);
    i_peer.stop_cond();
    // every cause has fired since the last clear: lost, ext, match, start, stop
    rdChk("irq status", bus_flags_pkg::IRQ_STATUS_ADDR, 32'h0000001F);
    testDone();
end
endmodule
bind bus_status_flags bus_flags_chk i_chk (.mclk(mclk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .arbLost(arbLost),
    .transmitState(transmitState), .sdaDrive(sdaDrive), .sdaOut(sdaOut),
    .sdaOeN(sdaOeN), .irq(irq));
